// >>> hw/mala_alarm_cell.sv
`timescale 1ns/100ps
module mala_alarm_cell
	import mala_pkg::*;
(
	// Clock and reset.
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	// Source control.
	input  wire logic i_cond,
	input  wire logic i_enable,
	input  wire logic i_latching,
	input  wire logic i_clear,
	// Contribution.
	output logic      o_active
);

	logic next_active;

	// A condition present in the clearing cycle keeps the bit set.
	assign next_active = i_enable & (i_cond | (i_latching & o_active & ~i_clear));

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_active <= 1'b0;
		end else begin
			o_active <= next_active;
		end
	end

endmodule

// >>> hw/mala_pkg.sv
package mala_pkg;

	// Register word offsets (byte addresses).
	localparam logic [7:0] REG_OPTIONS    = 8'h00;
	localparam logic [7:0] REG_MINOR_EN   = 8'h04;
	localparam logic [7:0] REG_CLUTCH_T   = 8'h08;
	localparam logic [7:0] REG_SRC_STATUS = 8'h0C;
	localparam logic [7:0] REG_STATUS     = 8'h10;

	// Reset values.
	localparam logic [15:0] OPTIONS_RST  = 16'h0000;
	localparam logic [15:0] MINOR_EN_RST = 16'h0000;
	localparam logic [15:0] CLUTCH_T_RST = 16'h01F4;

	// Alarm source indices within the 16-bit source vector.
	localparam int SRC_SPD1     = 0;
	localparam int SRC_SPD2     = 1;
	localparam int SRC_MANAIR   = 2;
	localparam int SRC_REMOTE   = 3;
	localparam int SRC_RACK     = 4;
	localparam int SRC_SPDSW    = 5;
	localparam int SRC_TORQUE   = 6;
	localparam int SRC_BOOST    = 7;
	localparam int SRC_HIGH_ACT = 8;
	localparam int SRC_PORT2    = 9;
	localparam int SRC_PORT3    = 10;
	localparam int SRC_PORT23   = 11;
	localparam int SRC_PID_LOW  = 12;
	localparam int SRC_OVSPD    = 13;
	localparam int SRC_LOADSW   = 14;
	localparam int SRC_CLUTCH   = 15;
	localparam int SRC_COUNT    = 16;

	// Sources that follow their condition; all others hold until reset.
	localparam logic [15:0] NON_LATCH_MASK = 16'h40E0;

	// Synchronizer bias gain in milli-percent per volt.
	localparam logic [15:0] SYNC_GAIN_HI = 16'h0BB8;
	localparam logic [15:0] SYNC_GAIN_LO = 16'h029B;

	// Clutch timing base.
	localparam int CLK_PERIOD_NS = 4;
	localparam int TICK_MS       = 10;
	localparam int TICK_CYCLES   = TICK_MS * 1000000 / CLK_PERIOD_NS;
	localparam int TICK_W        = 22;

	// Option flags, packed at bit positions 10 down to 0 of REG_OPTIONS.
	typedef struct packed {
		logic [4:0] reserved;
		logic       severe_fault_min_fuel_enable;
		logic       synchronizer_scale_select;
		logic       input_e_function_select;
		logic       manual_clutch_select;
		logic       input_f_function_select;
		logic       reverse_acting_select;
		logic       loss_of_speed_max_fuel_select;
		logic       remote_hold_last_enable;
		logic       port_engine_select;
		logic       boost_limit_enable;
		logic       torque_limit_enable;
	} mala_opt_t;

	// Raw fault conditions; bits 10 to 0 match the source indices, bits 13 to 11 feed sources 14 to 12.
	typedef struct packed {
		logic load_switch;
		logic overspeed_trip;
		logic controller_output_low_trip;
		logic port3_error;
		logic port2_error;
		logic high_act;
		logic boost_limiting;
		logic torque_limiting;
		logic speed_switch;
		logic rack_fail;
		logic remote_fail;
		logic manifold_air_fail;
		logic speed_pickup_sensor2_fail;
		logic speed_pickup_sensor1_fail;
	} mala_fault_t;

	typedef enum logic [1:0] {
		CL_IDLE,
		CL_TIMING,
		CL_FAILED
	} mala_clutch_state_t;

endpackage

// >>> hw/mala_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// R01 - Minor alarm output is the OR of all enabled source contributions.
// R02 - Each source has its own minor enable; a clear enable blocks it.
// R03 - Speed switch, torque, boost limiter and load switch follow their condition.
// R04 - Enabled port 2 link error raises the minor alarm.
// R05 - Enabled port 3 link error raises the minor alarm.
// R06 - Separate enable raises alarm only when ports 2 and 3 both fail.
// R07 - Enabled clutch failure alarms when engaged contact misses the sync time.
// R08 - Enabled controller-output-low fault raises the minor alarm.
// R09 - Enabled overspeed condition raises the minor alarm.
// R10 - Enabled load switch pickup raises the minor alarm while exceeded.
// R11 - Enabled maximum fuel limiting raises the minor alarm and latches until alarm reset.
// R12 - Speed loss commands maximum fuel only with override and reverse set.
// R13 - One flag selects direct or reverse actuator sense.
// R14 - Remote input failure holds last value or ramps to lower limit.
// R15 - Input F is overspeed test enable or emergency declutch request.
// R16 - Input E resets alarms or enables the second dynamics set.
// R17 - With shutdown flag set, any major alarm forces minimum fuel.
// R18 - Manual clutch never issues permissive; load sharing starts on engagement.
// R19 - Manual clutch still soft loads but never soft unloads.
// R20 - The companion controller holds the opposite port engine setting.
// R21 - Torque limiter and boost limiter work only while enabled.
// R22 - Synchronizer bias scales at 3 or 0.667 percent per volt.
// R23 - Latching sources stay set until an input E alarm reset.
// R24 - An active configuration menu forces every output off except the register read data.
module mala_top
	import mala_pkg::*;
#(
	parameter int P_TICK_CYCLES = TICK_CYCLES
)(
	// Clock and reset.
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// Register port.
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wr_data,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rd_data,
	// Fault and condition inputs.
	input  wire mala_fault_t i_faults,
	input  wire logic        i_speed_lost,
	input  wire logic        i_major_alarm,
	input  wire logic        i_config_active,
	// Discrete contacts.
	input  wire logic        i_input_e,
	input  wire logic        i_input_f,
	input  wire logic        i_clutch_engaged,
	// Clutch sequencer requests.
	input  wire logic        i_clutch_sync_go,
	input  wire logic        i_soft_load_req,
	input  wire logic        i_soft_unload_req,
	// Alarm and fuel outputs.
	output logic             o_minor_alarm,
	output logic             o_fuel_force_max,
	output logic             o_fuel_force_min,
	output logic             o_act_reverse,
	// Reference and mode outputs.
	output logic             o_hold_last,
	output logic             o_ramp_lower,
	output logic             o_overspeed_test_en,
	output logic             o_emerg_declutch,
	output logic             o_alarm_reset,
	output logic             o_dyn2_en,
	// Clutch and load outputs.
	output logic             o_clutch_permissive,
	output logic             o_load_share_start,
	output logic             o_soft_load_en,
	output logic             o_soft_unload_en,
	// Limiter and synchronizer outputs.
	output logic             o_torque_limit_en,
	output logic             o_boost_limit_en,
	output logic             o_port_engine,
	output logic      [15:0] o_sync_gain
);

	mala_opt_t              opt;
	logic [15:0]            minor_en;
	logic [15:0]            clutch_time;
	mala_clutch_state_t     cl_state;
	mala_clutch_state_t     next_cl_state;
	logic [TICK_W-1:0]      tick_cnt;
	logic                   tick;
	logic [15:0]            cl_count;
	logic [SRC_COUNT-1:0]   src_cond;
	logic [SRC_COUNT-1:0]   cell_active;
	logic                   run;

	// Register decode.
	wire wr_options  = i_wr && (i_addr == REG_OPTIONS);
	wire wr_minor_en = i_wr && (i_addr == REG_MINOR_EN);
	wire wr_clutch_t = i_wr && (i_addr == REG_CLUTCH_T);
	wire [31:0] rd_mux =
		(i_addr == REG_OPTIONS)    ? {16'h0000, opt}                        :
		(i_addr == REG_MINOR_EN)   ? {16'h0000, minor_en}                   :
		(i_addr == REG_CLUTCH_T)   ? {16'h0000, clutch_time}                :
		(i_addr == REG_SRC_STATUS) ? {16'h0000, cell_active}                :
		(i_addr == REG_STATUS)     ? {28'h0000000, cl_state, o_minor_alarm, run} :
		32'h00000000;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			opt         <= mala_opt_t'(OPTIONS_RST);
			minor_en    <= MINOR_EN_RST;
			clutch_time <= CLUTCH_T_RST;
			o_rd_data   <= 32'h00000000;
		end else begin
			if (wr_options) begin
				opt <= mala_opt_t'({5'h00, i_wr_data[10:0]});
			end
			if (wr_minor_en) begin
				minor_en <= i_wr_data[15:0];
			end
			if (wr_clutch_t) begin
				clutch_time <= i_wr_data[15:0];
			end
			o_rd_data <= i_rd ? rd_mux : 32'h00000000;
		end
	end

	// Menu lock: every output except o_rd_data is held off while configuration is active.
	assign run = ~i_config_active; // R24

	// Time base for the clutch synchronization window.
	wire tick_wrap = (tick_cnt == TICK_W'(P_TICK_CYCLES - 1));
	assign tick = tick_wrap;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n || !i_clutch_sync_go || tick_wrap) begin
			tick_cnt <= '0;
		end else begin
			tick_cnt <= tick_cnt + TICK_W'(1);
		end
	end

	// Clutch supervision: counts ticks from sync start until engagement or until the count reaches clutch_time.
	wire cl_expired = (cl_count >= clutch_time);

	always_comb begin
		next_cl_state = cl_state;
		unique case (cl_state)
			CL_IDLE: begin
				if (i_clutch_sync_go && !i_clutch_engaged) begin
					next_cl_state = CL_TIMING;
				end
			end
			CL_TIMING: begin
				if (!i_clutch_sync_go || i_clutch_engaged) begin
					next_cl_state = CL_IDLE;
				end else if (cl_expired) begin
					next_cl_state = CL_FAILED; // R07
				end
			end
			CL_FAILED: begin
				if (!i_clutch_sync_go || i_clutch_engaged) begin
					next_cl_state = CL_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cl_state <= CL_IDLE;
			cl_count <= 16'h0000;
		end else begin
			cl_state <= next_cl_state;
			// The count holds in the failed state so the expiry stays visible there.
			if (cl_state == CL_IDLE) begin
				cl_count <= 16'h0000;
			end else if (tick && !cl_expired) begin
				cl_count <= cl_count + 16'h0001;
			end
		end
	end

	// Source conditions feeding the per-source alarm cells.
	assign src_cond[SRC_SPD1]     = i_faults.speed_pickup_sensor1_fail;
	assign src_cond[SRC_SPD2]     = i_faults.speed_pickup_sensor2_fail;
	assign src_cond[SRC_MANAIR]   = i_faults.manifold_air_fail;
	assign src_cond[SRC_REMOTE]   = i_faults.remote_fail;
	assign src_cond[SRC_RACK]     = i_faults.rack_fail;
	assign src_cond[SRC_SPDSW]    = i_faults.speed_switch;
	assign src_cond[SRC_TORQUE]   = i_faults.torque_limiting & opt.torque_limit_enable; // R21
	assign src_cond[SRC_BOOST]    = i_faults.boost_limiting & opt.boost_limit_enable; // R21
	assign src_cond[SRC_HIGH_ACT] = i_faults.high_act; // R11
	assign src_cond[SRC_PORT2]    = i_faults.port2_error; // R04
	assign src_cond[SRC_PORT3]    = i_faults.port3_error; // R05
	assign src_cond[SRC_PORT23]   = i_faults.port2_error & i_faults.port3_error; // R06
	assign src_cond[SRC_PID_LOW]  = i_faults.controller_output_low_trip; // R08
	assign src_cond[SRC_OVSPD]    = i_faults.overspeed_trip; // R09
	assign src_cond[SRC_LOADSW]   = i_faults.load_switch; // R10
	assign src_cond[SRC_CLUTCH]   = (cl_state == CL_FAILED); // R07

	wire alarm_clear = i_input_e & opt.input_e_function_select; // R16

	genvar g;
	generate
		for (g = 0; g < SRC_COUNT; g++) begin : g_src
			mala_alarm_cell u_cell (
				.i_clk      (i_clk),
				.i_rst_n    (i_rst_n),
				.i_cond     (src_cond[g]),
				.i_enable   (minor_en[g]), // R02
				.i_latching (~NON_LATCH_MASK[g]), // R03
				.i_clear    (alarm_clear), // R23
				.o_active   (cell_active[g])
			);
		end
	endgenerate

	// Decisions before the menu lock.
	wire nx_minor      = |cell_active; // R01
	wire nx_fuel_min   = (opt.severe_fault_min_fuel_enable & i_major_alarm) // R17
		| (i_speed_lost & ~(opt.loss_of_speed_max_fuel_select
		& opt.reverse_acting_select)); // R12
	wire nx_fuel_max   = i_speed_lost & opt.loss_of_speed_max_fuel_select
		& opt.reverse_acting_select & ~nx_fuel_min; // R12
	wire nx_hold_last  = i_faults.remote_fail & opt.remote_hold_last_enable; // R14
	wire nx_ramp_lower = i_faults.remote_fail & ~opt.remote_hold_last_enable; // R14
	wire nx_os_test    = i_input_f & opt.input_f_function_select; // R15
	wire nx_declutch   = i_input_f & ~opt.input_f_function_select; // R15
	wire nx_dyn2       = i_input_e & ~opt.input_e_function_select; // R16
	wire nx_permissive = i_clutch_sync_go & ~opt.manual_clutch_select
		& (cl_state != CL_FAILED); // R18
	wire nx_unload     = i_soft_unload_req & ~opt.manual_clutch_select; // R19
	wire [15:0] nx_gain = opt.synchronizer_scale_select ? SYNC_GAIN_HI : SYNC_GAIN_LO; // R22

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_minor_alarm       <= 1'b0;
			o_fuel_force_max    <= 1'b0;
			o_fuel_force_min    <= 1'b0;
			o_act_reverse       <= 1'b0;
			o_hold_last         <= 1'b0;
			o_ramp_lower        <= 1'b0;
			o_overspeed_test_en <= 1'b0;
			o_emerg_declutch    <= 1'b0;
			o_alarm_reset       <= 1'b0;
			o_dyn2_en           <= 1'b0;
			o_clutch_permissive <= 1'b0;
			o_load_share_start  <= 1'b0;
			o_soft_load_en      <= 1'b0;
			o_soft_unload_en    <= 1'b0;
			o_torque_limit_en   <= 1'b0;
			o_boost_limit_en    <= 1'b0;
			o_port_engine       <= 1'b0;
			o_sync_gain         <= 16'h0000;
		end else begin
			o_minor_alarm       <= run & nx_minor; // R24
			o_fuel_force_max    <= run & nx_fuel_max;
			o_fuel_force_min    <= run & nx_fuel_min;
			o_act_reverse       <= run & opt.reverse_acting_select; // R13
			o_hold_last         <= run & nx_hold_last;
			o_ramp_lower        <= run & nx_ramp_lower;
			o_overspeed_test_en <= run & nx_os_test;
			o_emerg_declutch    <= run & nx_declutch;
			o_alarm_reset       <= run & alarm_clear;
			o_dyn2_en           <= run & nx_dyn2;
			o_clutch_permissive <= run & nx_permissive;
			o_load_share_start  <= run & i_clutch_engaged; // R18
			o_soft_load_en      <= run & i_soft_load_req; // R19
			o_soft_unload_en    <= run & nx_unload;
			o_torque_limit_en   <= run & opt.torque_limit_enable; // R21
			o_boost_limit_en    <= run & opt.boost_limit_enable; // R21
			o_port_engine       <= run & opt.port_engine_select; // R20
			o_sync_gain         <= run ? nx_gain : 16'h0000;
		end
	end

	// An enabled overspeed held for two cycles reaches the relay output.
	a_overspeed_raises: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R09
		(i_faults.overspeed_trip && minor_en[SRC_OVSPD] && !i_config_active && !i_wr)[*2]
		|=> o_minor_alarm)
		else $error("enabled overspeed did not raise minor alarm");

	a_enables_block: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R02
		(minor_en == 16'h0000)[*2] |=> !o_minor_alarm)
		else $error("minor alarm raised with all enables clear");

	a_nonlatch_follows: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R03
		!i_faults.speed_switch |=> !cell_active[SRC_SPDSW])
		else $error("speed switch contribution outlived its condition");

	a_latch_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R23
		(cell_active[SRC_SPD1] && minor_en[SRC_SPD1] && !alarm_clear && !i_wr)
		|=> cell_active[SRC_SPD1])
		else $error("latched sensor alarm dropped without reset");

	a_port_pair: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R06
		$rose(cell_active[SRC_PORT23]) |-> $past(i_faults.port2_error && i_faults.port3_error))
		else $error("pair link alarm set without both ports failing");

	a_clutch_timeout: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R07
		(cl_state == CL_FAILED) |-> $past(cl_count >= clutch_time) && !$past(i_clutch_engaged))
		else $error("clutch failure declared before the sync time");

	a_max_fuel_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R12
		o_fuel_force_max |-> $past(i_speed_lost && opt.loss_of_speed_max_fuel_select
		&& opt.reverse_acting_select))
		else $error("maximum fuel without override and reverse sense");

	a_shutdown_min: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R17
		(i_major_alarm && opt.severe_fault_min_fuel_enable && !i_config_active)
		|=> o_fuel_force_min && !o_fuel_force_max)
		else $error("major alarm did not force minimum fuel");

	a_manual_clutch: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R18
		opt.manual_clutch_select |=> !o_clutch_permissive && !o_soft_unload_en)
		else $error("manual clutch issued permissive or soft unload");

	a_menu_lock: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R24
		i_config_active |=> !o_minor_alarm && !o_fuel_force_min && !o_clutch_permissive
		&& !o_act_reverse && (o_sync_gain == 16'h0000))
		else $error("outputs active during configuration");

	a_alarm_or: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R01
		(|cell_active && !i_config_active) |=> o_minor_alarm)
		else $error("active source did not reach the minor alarm");

	a_port2_raises: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R04
		(i_faults.port2_error && minor_en[SRC_PORT2]) |=> cell_active[SRC_PORT2])
		else $error("enabled port 2 error did not set its source");

	a_port3_raises: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R05
		(i_faults.port3_error && minor_en[SRC_PORT3]) |=> cell_active[SRC_PORT3])
		else $error("enabled port 3 error did not set its source");

	a_low_out_raises: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R08
		(i_faults.controller_output_low_trip && minor_en[SRC_PID_LOW]) |=> cell_active[SRC_PID_LOW])
		else $error("enabled output-low fault did not set its source");

	a_load_switch: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R10
		(i_faults.load_switch && minor_en[SRC_LOADSW]) |=> cell_active[SRC_LOADSW])
		else $error("enabled load switch did not set its source");

	a_max_fuel_limit: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R11
		(i_faults.high_act && minor_en[SRC_HIGH_ACT]) |=> cell_active[SRC_HIGH_ACT])
		else $error("enabled fuel limiting did not set its source");

	a_remote_action: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R14
		(i_faults.remote_fail && !i_config_active) |=> (o_hold_last != o_ramp_lower))
		else $error("remote failure did not pick exactly one reference action");

	a_input_f_route: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R15
		(i_input_f && !i_config_active) |=> (o_overspeed_test_en != o_emerg_declutch))
		else $error("input F did not reach exactly one function");

	a_sync_gain: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R22
		!i_config_active |=> (o_sync_gain == SYNC_GAIN_HI || o_sync_gain == SYNC_GAIN_LO))
		else $error("synchronizer gain is neither scale");

endmodule

// >>> tb/mala_plant.sv
`timescale 1ns/100ps
module mala_plant
	import mala_pkg::*;
(
	// Clock.
	input  wire logic        i_clk,
	// Fault commands from the bench and the port engine setting from the block.
	input  wire mala_fault_t i_fault_cmd,
	input  wire logic        i_port_engine,
	// Conditions seen by the block, and the companion port seen by the bench.
	output mala_fault_t      o_faults,
	output logic             o_companion_port
);
	// Sensor conditioning shows each condition one cycle after it arises.
	always_ff @(posedge i_clk) begin
		o_faults <= i_fault_cmd;
	end
	// The companion unit on the gearbox always claims the other side.
	assign o_companion_port = ~i_port_engine;
endmodule

// >>> tb/mala_top_bench.sv
`timescale 1ns/100ps
module mala_top_bench
	import mala_pkg::*;
;
	logic        i_clk, i_rst_n, i_wr, i_rd, i_speed_lost, i_major_alarm, i_config_active;
	logic        i_input_e, i_input_f, i_clutch_engaged, i_clutch_sync_go;
	logic        i_soft_load_req, i_soft_unload_req;
	logic [7:0]  i_addr;
	logic [31:0] i_wr_data, o_rd_data;
	logic [15:0] o_sync_gain, en;
	logic        o_minor_alarm, o_fuel_force_max, o_fuel_force_min, o_act_reverse, o_hold_last;
	logic        o_ramp_lower, o_overspeed_test_en, o_emerg_declutch, o_alarm_reset, o_dyn2_en;
	logic        o_clutch_permissive, o_load_share_start, o_soft_load_en, o_soft_unload_en;
	logic        o_torque_limit_en, o_boost_limit_en, o_port_engine, companion, mn;
	logic        rd_d = 1'b0;
	logic [13:0] f;
	logic [10:0] o;
	logic [7:0]  l;
	mala_fault_t cmd, faults;
	logic [31:0] exp_q[$];
	int          miscompares = 0;
	int          n_tests = 0;
	int          n;

	mala_plant plant (.i_clk, .i_fault_cmd(cmd), .i_port_engine(o_port_engine),
		.o_faults(faults), .o_companion_port(companion));

	mala_top #(.P_TICK_CYCLES(4)) dut (.i_clk, .i_rst_n, .i_addr, .i_wr_data, .i_wr, .i_rd,
		.o_rd_data, .i_faults(faults), .i_speed_lost, .i_major_alarm, .i_config_active,
		.i_input_e, .i_input_f, .i_clutch_engaged, .i_clutch_sync_go, .i_soft_load_req,
		.i_soft_unload_req, .o_minor_alarm, .o_fuel_force_max, .o_fuel_force_min,
		.o_act_reverse, .o_hold_last, .o_ramp_lower, .o_overspeed_test_en, .o_emerg_declutch,
		.o_alarm_reset, .o_dyn2_en, .o_clutch_permissive, .o_load_share_start,
		.o_soft_load_en, .o_soft_unload_en, .o_torque_limit_en, .o_boost_limit_en,
		.o_port_engine, .o_sync_gain);

	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("Checks made %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Read data stands only in the cycle after the strobe, so it is taken at that edge.
	always @(posedge i_clk) begin
		rd_d <= i_rd;
		if (rd_d === 1'b1) begin
			chk("rd_data", o_rd_data, exp_q.pop_front());
		end
	end

	task automatic cyc(input int k);
		repeat (k) @(posedge i_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_addr <= a;
		i_wr_data <= d;
		i_wr <= 1'b1;
		cyc(1);
		i_wr <= 1'b0;
		cyc(1);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		i_addr <= a;
		i_rd <= 1'b1;
		cyc(1);
		i_rd <= 1'b0;
		cyc(1);
	endtask

	// Drops every condition and holds the alarm reset contact long enough to clear latches.
	task automatic clr();
		cmd <= '0;
		i_input_e <= 1'b1;
		cyc(4);
		i_input_e <= 1'b0;
		cyc(2);
	endtask

	function automatic logic [15:0] src_of(input logic [13:0] c);
		return {1'b0, c[13:11], c[9] & c[10], c[10:0]};
	endfunction

	initial begin
		repeat (20000) @(posedge i_clk);
		miscompares++;
		wrap_up();
	end

	initial begin
		{i_rst_n, i_wr, i_rd, i_speed_lost, i_major_alarm, i_config_active} = '0;
		{i_input_e, i_input_f, i_clutch_engaged, i_clutch_sync_go} = '0;
		{i_soft_load_req, i_soft_unload_req} = '0;
		i_addr = '0;
		i_wr_data = '0;
		cmd = '0;
		void'($urandom(95757));
		cyc(4);
		i_rst_n <= 1'b1;
		cyc(1);
		rd(REG_OPTIONS, {16'h0000, OPTIONS_RST});
		rd(REG_MINOR_EN, {16'h0000, MINOR_EN_RST});
		rd(REG_CLUTCH_T, {16'h0000, CLUTCH_T_RST});
		rd(8'h20, 32'h0000_0000);
		wr(REG_MINOR_EN, 32'hFFFF_FFFF);
		rd(REG_MINOR_EN, 32'h0000_FFFF);
		wr(REG_OPTIONS, 32'h0000_0103);
		for (int t = 0; t < 12; t++) begin
			f = 14'($urandom);
			en = 16'($urandom);
			if (t < 2) begin
				f = (t == 0) ? 14'h0200 : 14'h0600;
				en = 16'h0800;
			end
			wr(REG_MINOR_EN, {16'h0000, en});
			cmd <= f;
			cyc(6);
			rd(REG_SRC_STATUS, {16'h0000, en & src_of(f)});
			chk("minor", {31'h0, o_minor_alarm}, {31'h0, |(en & src_of(f))});
			clr();
		end
		wr(REG_MINOR_EN, 32'h0000_FFFF);
		cmd <= 14'h1020;
		cyc(6);
		cmd <= '0;
		cyc(6);
		rd(REG_SRC_STATUS, 32'h0000_2000);
		clr();
		rd(REG_SRC_STATUS, 32'h0000_0000);
		wr(REG_OPTIONS, 32'h0000_0323);
		i_config_active <= 1'b1;
		cmd <= 14'h3FFF;
		cyc(6);
		chk("cfg", 32'({o_minor_alarm, o_act_reverse, o_torque_limit_en, o_sync_gain}), 0);
		i_config_active <= 1'b0;
		cyc(3);
		chk("run", 32'({o_minor_alarm, o_act_reverse, o_torque_limit_en, o_sync_gain}),
			{13'h0, 3'b111, SYNC_GAIN_HI});
		clr();
		wr(REG_MINOR_EN, 32'h0000_0000);
		for (int t = 0; t < 24; t++) begin
			o = 11'($urandom);
			l = 8'($urandom);
			wr(REG_OPTIONS, {21'h0, o});
			{i_speed_lost, i_major_alarm, i_input_e, i_input_f} <= l[6:3];
			{i_clutch_sync_go, i_soft_load_req, i_soft_unload_req} <= l[2:0];
			cmd <= {10'h0, l[7], 3'h0};
			cyc(4);
			mn = (l[5] & o[10]) | (l[6] & ~(o[4] & o[5]));
			chk("modes", 32'({o_fuel_force_min, o_fuel_force_max, o_act_reverse, o_hold_last,
				o_ramp_lower, o_overspeed_test_en, o_emerg_declutch, o_alarm_reset, o_dyn2_en,
				o_clutch_permissive, o_soft_load_en, o_soft_unload_en, o_torque_limit_en,
				o_boost_limit_en, o_port_engine}), 32'({mn, l[6] & o[4] & o[5] & ~mn, o[5],
				l[7] & o[3], l[7] & ~o[3], l[3] & o[6], l[3] & ~o[6], l[4] & o[8], l[4] & ~o[8],
				l[2] & ~o[7], l[1], l[0] & ~o[7], o[0], o[1], o[2]}));
			chk("gain", 32'(o_sync_gain), 32'(o[9] ? SYNC_GAIN_HI : SYNC_GAIN_LO));
			chk("companion", {31'h0, companion}, {31'h0, ~o[2]});
		end
		{i_speed_lost, i_major_alarm, i_input_e, i_input_f} <= '0;
		{i_clutch_sync_go, i_soft_load_req, i_soft_unload_req} <= '0;
		cmd <= '0;
		wr(REG_CLUTCH_T, 32'h0000_0003);
		wr(REG_MINOR_EN, 32'h0000_8000);
		wr(REG_OPTIONS, 32'h0000_0100);
		i_clutch_sync_go <= 1'b1;
		cyc(3);
		rd(REG_STATUS, 32'h0000_0005);
		n = 5;
		while (o_clutch_permissive === 1'b1 && n < 60) begin
			cyc(1);
			n++;
		end
		chk("fail_time", 32'(n >= 10 && n < 60), 32'h0000_0001);
		cyc(3);
		rd(REG_STATUS, 32'h0000_000B);
		i_clutch_engaged <= 1'b1;
		i_clutch_sync_go <= 1'b0;
		cyc(3);
		rd(REG_STATUS, 32'h0000_0003);
		clr();
		rd(REG_STATUS, 32'h0000_0001);
		wr(REG_OPTIONS, 32'h0000_0180);
		i_clutch_sync_go <= 1'b1;
		cyc(3);
		chk("permissive", {31'h0, o_clutch_permissive}, 32'h0000_0000);
		chk("load_share", {31'h0, o_load_share_start}, 32'h0000_0001);
		cyc(4);
		wrap_up();
	end
endmodule
